// file: core/mlc_pkg.sv
// Purpose: constants for the mass lock and centre controller
// Assumes: core_clk at 250 MHz
// Notes:   long counts are top-level parameters
package mlc_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned HOLD_TIME_S    = 7;
  localparam longint      HOLD_CYCLES    = longint'(HOLD_TIME_S) * CLK_HZ;
  localparam int unsigned STAGE_TIME_MS  = 2000;
  localparam int unsigned TILT_TIME_MS   = 6000;
  localparam int unsigned GAP_TIME_MS    = 250;
  localparam int unsigned BLINK_TIME_MS  = 125;
  localparam longint      STAGE_CYCLES   = longint'(STAGE_TIME_MS) * (CLK_HZ / 1000);
  localparam longint      TILT_CYCLES    = longint'(TILT_TIME_MS) * (CLK_HZ / 1000);
  localparam longint      GAP_CYCLES     = longint'(GAP_TIME_MS) * (CLK_HZ / 1000);
  localparam longint      BLINK_CYCLES   = longint'(BLINK_TIME_MS) * (CLK_HZ / 1000);
  localparam int          CNT_W          = 32;
  localparam int          N_CMD          = 3;
  localparam int          CMD_LOCK       = 0;
  localparam int          CMD_UNLOCK     = 1;
  localparam int          CMD_CENTRE     = 2;
  localparam int          N_AXIS         = 3;
  localparam int          AX_Z           = 0;
  localparam int          AX_NS          = 1;
  localparam int          AX_EW          = 2;
  typedef enum logic [1:0] {SEQ_NONE, SEQ_LOCK, SEQ_UNLOCK, SEQ_CENTRE}
    mlc_seq_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_RUN, ST_GAP}
    mlc_state_type;
endpackage

// file: core/mlc_hold_filter.sv
// Purpose: qualify one active-low command line by hold time
// Assumes: line asynchronous to core_clk
// Notes:   one-cycle pulse once the line has stayed low long enough
`timescale 1ns/1ns
`default_nettype none
module mlc_hold_filter
  import mlc_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD = CNT_W'(HOLD_CYCLES)
)(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic line_n,
  output logic      held,
  output logic      fire
);
  typedef struct packed {
    logic             s1;
    logic             s2;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic             fire;
  } mlc_flt_type;
  mlc_flt_type st_reg, st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = line_n;
    st_next.s2   = st_reg.s1;
    st_next.fire = 1'b0;
    if (st_reg.s2)
    begin
      st_next.cnt  = '0;
      st_next.done = 1'b0;
    end
    else if (!st_reg.done)
    begin
      if (st_reg.cnt >= HOLD - 1'b1)
      begin
        st_next.done = 1'b1;
        st_next.fire = 1'b1;
      end
      else
        st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '{s1: 1'b1, s2: 1'b1, cnt: '0, done: 1'b0, fire: 1'b0};
    else
      st_reg <= st_next;
  end

  assign fire = st_reg.fire;
  assign held = !st_reg.s2;

  chk_fire_after_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    st_reg.fire |-> $past(st_reg.cnt) == HOLD - 1'b1)
    else $error("fire without full hold count");
  chk_high_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    st_reg.s2 |=> st_reg.cnt == '0 && !st_reg.fire)
    else $error("count not restarted on high line");
endmodule
`default_nettype wire

// file: core/mlc_ctrl.sv
// Purpose: sequence lock, unlock and centre across three masses
// Assumes: limit switches and offset comparators arrive as levels
// Notes:   stage times are parameters so simulation can shorten them
`timescale 1ns/1ns
`default_nettype none
module mlc_ctrl
  import mlc_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD  = CNT_W'(HOLD_CYCLES),
  parameter logic [CNT_W-1:0] STAGE = CNT_W'(STAGE_CYCLES),
  parameter logic [CNT_W-1:0] TILT  = CNT_W'(TILT_CYCLES),
  parameter logic [CNT_W-1:0] GAP   = CNT_W'(GAP_CYCLES),
  parameter logic [CNT_W-1:0] BLINK = CNT_W'(BLINK_CYCLES)
)(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                lock_cmd_n,
  input  wire logic                unlock_cmd_n,
  input  wire logic                centre_cmd_n,
  input  wire logic [N_AXIS-1:0]   mass_clamped,
  input  wire logic [N_AXIS-1:0]   offset_over,
  input  wire logic [N_AXIS-1:0]   cal_enable,
  output logic [N_AXIS-1:0]        clamp_lock,
  output logic [N_AXIS-1:0]        clamp_release,
  output logic [1:0]               base_tilt_lock,
  output logic [1:0]               base_tilt_release,
  output logic [N_AXIS-1:0]        centre_drive,
  output logic [N_AXIS-1:0]        cal_relay,
  output logic                     busy_led,
  output logic                     power_save
);
  logic [N_CMD-1:0] line_n;
  logic [N_CMD-1:0] held;
  logic [N_CMD-1:0] fire;
  logic [N_CMD-1:0] line_n_sync;
  logic [12:0]      motor_bits;

  default clocking cb_main @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic [N_AXIS-1:0] cal_s1_reg;
  logic [N_AXIS-1:0] cal_s2_reg;
  logic [N_AXIS-1:0] clmp_s1_reg;
  logic [N_AXIS-1:0] clmp_s2_reg;
  logic [N_AXIS-1:0] off_s1_reg;
  logic [N_AXIS-1:0] off_s2_reg;

  assign line_n[CMD_LOCK]   = lock_cmd_n;
  assign line_n[CMD_UNLOCK] = unlock_cmd_n;
  assign line_n[CMD_CENTRE] = centre_cmd_n;
  assign line_n_sync        = ~held;

  genvar gi;
  generate
    for (gi = 0; gi < N_CMD; gi++)
    begin : g_flt
      mlc_hold_filter #(.HOLD(HOLD)) u_flt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .line_n   (line_n[gi]),
        .held     (held[gi]),
        .fire     (fire[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cal_s1_reg  <= '0;
      cal_s2_reg  <= '0;
      clmp_s1_reg <= '0;
      clmp_s2_reg <= '0;
      off_s1_reg  <= '0;
      off_s2_reg  <= '0;
    end
    else
    begin
      cal_s1_reg  <= cal_enable;
      cal_s2_reg  <= cal_s1_reg;
      clmp_s1_reg <= mass_clamped;
      clmp_s2_reg <= clmp_s1_reg;
      off_s1_reg  <= offset_over;
      off_s2_reg  <= off_s1_reg;
    end
  end

  typedef struct packed {
    mlc_state_type    state;
    mlc_seq_type      seq;
    logic [2:0]       stage;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] blink_tmr;
    logic             blink;
    logic             chain_centre;
    logic [N_AXIS-1:0] clamp_lock;
    logic [N_AXIS-1:0] clamp_release;
    logic [1:0]       tilt_lock;
    logic [1:0]       tilt_release;
    logic [N_AXIS-1:0] centre_drive;
    logic [N_AXIS-1:0] cal_relay;
    logic             busy;
    logic             psave;
  } mlc_ctrl_type;
  mlc_ctrl_type st_reg, st_next;

  logic clamped_any;
  logic [2:0] last_stage;
  logic [CNT_W-1:0] stage_len;
  assign clamped_any = |clmp_s2_reg;

  always_comb
  begin
    last_stage = 3'h4;
    stage_len  = STAGE;
    case (st_reg.seq)
      SEQ_LOCK:
      begin
        last_stage = 3'h4;
        stage_len  = (st_reg.stage >= 3'h3) ? TILT : STAGE;
      end
      SEQ_UNLOCK:
      begin
        last_stage = 3'h4;
        stage_len  = (st_reg.stage >= 3'h3) ? TILT : STAGE;
      end
      SEQ_CENTRE:
      begin
        last_stage = 3'h2;
        stage_len  = STAGE;
      end
      default:
      begin
        last_stage = 3'h4;
        stage_len  = STAGE;
      end
    endcase
  end

  always_comb
  begin
    st_next               = st_reg;
    st_next.clamp_lock    = '0;
    st_next.clamp_release = '0;
    st_next.tilt_lock     = '0;
    st_next.tilt_release  = '0;
    st_next.centre_drive  = '0;
    st_next.cal_relay     = cal_s2_reg;
    st_next.busy          = 1'b0;
    st_next.psave         = 1'b0;
    case (st_reg.state)
      ST_IDLE:
      begin
        st_next.psave = &line_n_sync;
        if (fire[CMD_LOCK])
        begin
          st_next.seq   = SEQ_LOCK;
          st_next.state = ST_RUN;
          st_next.stage = 3'h0;
          st_next.tmr   = '0;
        end
        else if (fire[CMD_UNLOCK])
        begin
          st_next.seq   = SEQ_UNLOCK;
          st_next.state = ST_CHECK;
        end
        else if (fire[CMD_CENTRE] && !clamped_any && (|off_s2_reg))
        begin
          st_next.seq   = SEQ_CENTRE;
          st_next.state = ST_RUN;
          st_next.stage = 3'h0;
          st_next.tmr   = '0;
        end
      end
      ST_CHECK:
      begin
        st_next.busy  = 1'b1;
        st_next.stage = 3'h0;
        st_next.tmr   = '0;
        st_next.chain_centre = 1'b1;
        st_next.state = ST_RUN;
      end
      ST_RUN:
      begin
        st_next.busy = (st_reg.seq == SEQ_LOCK) ? 1'b1 : st_reg.blink;
        case (st_reg.seq)
          SEQ_LOCK:
          begin
            if (st_reg.stage < 3'h3)
              st_next.clamp_lock[st_reg.stage[1:0]] = 1'b1;
            else
              st_next.tilt_lock[st_reg.stage[0] ? 0 : 1] = 1'b1;
          end
          SEQ_UNLOCK:
          begin
            if (st_reg.stage < 3'h3)
              st_next.clamp_release[st_reg.stage[1:0]] = 1'b1;
            else
              st_next.tilt_release[st_reg.stage[0] ? 0 : 1] = 1'b1;
          end
          default:
            st_next.centre_drive[st_reg.stage[1:0]] =
              off_s2_reg[st_reg.stage[1:0]];
        endcase
        if (st_reg.tmr >= stage_len - 1'b1)
        begin
          st_next.tmr = '0;
          if (st_reg.stage == last_stage)
          begin
            if (st_reg.seq == SEQ_UNLOCK && st_reg.chain_centre)
            begin
              st_next.seq   = SEQ_CENTRE;
              st_next.stage = 3'h0;
              st_next.chain_centre = 1'b0;
            end
            else
            begin
              st_next.state = ST_IDLE;
              st_next.seq   = SEQ_NONE;
            end
          end
          else
            st_next.state = ST_GAP;
        end
        else
          st_next.tmr = st_reg.tmr + 1'b1;
      end
      ST_GAP:
      begin
        st_next.busy = 1'b0;
        if (st_reg.tmr >= GAP - 1'b1)
        begin
          st_next.tmr   = '0;
          st_next.stage = st_reg.stage + 3'h1;
          st_next.state = ST_RUN;
        end
        else
          st_next.tmr = st_reg.tmr + 1'b1;
      end
      default:
        st_next.state = ST_IDLE;
    endcase
    if (st_reg.blink_tmr >= BLINK - 1'b1)
    begin
      st_next.blink_tmr = '0;
      st_next.blink     = !st_reg.blink;
    end
    else
      st_next.blink_tmr = st_reg.blink_tmr + 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign clamp_lock        = st_reg.clamp_lock;
  assign clamp_release     = st_reg.clamp_release;
  assign base_tilt_lock    = st_reg.tilt_lock;
  assign base_tilt_release = st_reg.tilt_release;
  assign centre_drive      = st_reg.centre_drive;
  assign cal_relay         = st_reg.cal_relay;
  assign busy_led          = st_reg.busy;
  assign power_save        = st_reg.psave;
  assign motor_bits        = {centre_drive, base_tilt_release, clamp_release,
                              base_tilt_lock, clamp_lock};

  chk_one_motor: assert property ($onehot0(motor_bits))
    else $error("two motor stages driven at once");
  chk_gap_dark: assert property (
    st_reg.state == ST_GAP |=> !busy_led)
    else $error("busy lit during gap");
  chk_lock_lit: assert property (
    st_reg.state == ST_RUN && st_reg.seq == SEQ_LOCK |=> busy_led)
    else $error("busy dark during lock stage");
  chk_centre_refused: assert property (
    st_reg.state == ST_IDLE && fire[CMD_CENTRE] && !fire[CMD_LOCK]
    && !fire[CMD_UNLOCK] && (clamped_any || !(|off_s2_reg))
    |=> st_reg.state == ST_IDLE)
    else $error("centre accepted while it must be refused");
  chk_psave_idle: assert property (
    st_reg.state != ST_IDLE |=> !power_save)
    else $error("power save during a sequence");
  chk_relay_follow: assert property (
    cal_relay == $past(cal_s2_reg))
    else $error("relay does not follow calibration input");

  cov_lock_last: cover property (
    st_reg.seq == SEQ_LOCK && st_reg.state == ST_RUN && st_reg.stage == 3'h4);
  cov_unlock_chain: cover property (
    st_reg.seq == SEQ_UNLOCK ##1 st_reg.seq == SEQ_CENTRE);
  cov_centre_drive: cover property (|centre_drive);
endmodule
`default_nettype wire

// file: test/mlc_box.sv
// Purpose: breakout box and mechanics seen by the controller
// Assumes: command lines are pulled up while released
// Notes:   masses start clamped, offsets clear once driven
`timescale 1ns/1ns
`default_nettype none
module mlc_box
  import mlc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              set_off,
  input  wire logic [N_AXIS-1:0] clamp_lock,
  input  wire logic [N_AXIS-1:0] clamp_release,
  input  wire logic [N_AXIS-1:0] centre_drive,
  output var logic [N_CMD-1:0]   cmd_n,
  output var logic [N_AXIS-1:0]  mass_clamped,
  output var logic [N_AXIS-1:0]  offset_over
);
  initial
  begin
    cmd_n        = '1;
    mass_clamped = '1;
    offset_over  = '0;
  end
  // hold one line low, then let it float back high
  task automatic press(input int idx, input int cycles);
    @(posedge core_clk);
    cmd_n[idx] <= 1'b0;
    repeat (cycles) @(posedge core_clk);
    cmd_n[idx] <= 1'b1;
  endtask
  always @(posedge core_clk)
  begin
    mass_clamped <= (mass_clamped | clamp_lock) & ~clamp_release;
    offset_over  <= set_off ? '1 : offset_over & ~centre_drive;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench for the mass lock controller
// Assumes: shortened hold and stage counts
// Notes:   motor outputs are logged by first rise per command
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mlc_pkg::*;
  localparam int H = 20;
  logic              core_clk = 1'b0;
  logic              resetn   = 1'b0;
  logic              set_off  = 1'b0;
  logic [N_AXIS-1:0] cal_en   = '0;
  logic [N_CMD-1:0]  cmd_n;
  logic [N_AXIS-1:0] clamped, over, cl, cr, cd, relay;
  logic [1:0]        tl, tr;
  logic              busy, psave;
  logic [12:0]       mot, seen_m;
  int                failures, num_checks, cyc, falls, multi, dur[13];
  int                ord[$];

  always #2 core_clk = ~core_clk;

  mlc_box box (.core_clk(core_clk), .set_off(set_off), .clamp_lock(cl),
    .clamp_release(cr), .centre_drive(cd), .cmd_n(cmd_n),
    .mass_clamped(clamped), .offset_over(over));

  mlc_ctrl #(.HOLD(H), .STAGE(20), .TILT(60), .GAP(8), .BLINK(4)) dut (
    .core_clk(core_clk), .resetn(resetn), .lock_cmd_n(cmd_n[CMD_LOCK]),
    .unlock_cmd_n(cmd_n[CMD_UNLOCK]), .centre_cmd_n(cmd_n[CMD_CENTRE]),
    .mass_clamped(clamped), .offset_over(over), .cal_enable(cal_en),
    .clamp_lock(cl), .clamp_release(cr), .base_tilt_lock(tl),
    .base_tilt_release(tr), .centre_drive(cd), .cal_relay(relay),
    .busy_led(busy), .power_save(psave));

  assign mot = {cd, tr, cr, tl, cl};

  always @(posedge core_clk)
  begin
    cyc++;
    if ($countones(mot) > 1)
      multi++;
    if ($fell(busy))
      falls++;
    for (int i = 0; i < 13; i++)
    begin
      dur[i] += int'(mot[i] === 1'b1);
      if (mot[i] === 1'b1 && !seen_m[i])
        ord.push_back(i);
      if (mot[i] === 1'b1)
        seen_m[i] = 1'b1;
    end
    if (cyc == 6000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s exp %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic clear();
    @(negedge core_clk);
    ord.delete();
    seen_m = '0;
    falls  = 0;
    multi  = 0;
    foreach (dur[i])
      dur[i] = 0;
  endtask

  // press one line, then wait for the return to idle
  task automatic run(input int idx, input int n);
    int k;
    clear();
    box.press(idx, n);
    k = 0;
    while (psave !== 1'b1 && k < 3000)
    begin
      @(posedge core_clk);
      k++;
    end
    check("idle", psave, 1'b1);
    repeat (5) @(posedge core_clk);
  endtask

  task automatic order(input string name, input int exp[$]);
    check(name, ord.size(), exp.size());
    foreach (exp[i])
      if (i < ord.size())
        check(name, ord[i], exp[i]);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("psave", psave, 1'b1);
    check("busy", busy, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      cal_en <= i[2:0];
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check("relay", relay, i);
    end
    @(posedge core_clk);
    set_off <= 1'b1;
    @(posedge core_clk);
    set_off <= 1'b0;
    run(CMD_CENTRE, H + 3);
    check("centre_clamped", seen_m, 13'h0);
    box.press(CMD_LOCK, H - 3);
    run(CMD_LOCK, H - 3);
    check("short_press", seen_m, 13'h0);
    run(CMD_UNLOCK, H + 3);
    order("unlock", {5, 6, 7, 8, 9, 10, 11, 12});
    check("released", clamped, 3'h0);
    check("multi_u", multi, 0);
    check("busy_u", falls != 0, 1'b1);
    run(CMD_CENTRE, H + 3);
    check("centre_none", seen_m, 13'h0);
    fork
      run(CMD_LOCK, H + 3);
      begin
        repeat (H + 30) @(posedge core_clk);
        box.press(CMD_UNLOCK, H + 3);
      end
    join
    order("lock", {0, 1, 2, 3, 4});
    check("falls", falls, 5);
    check("tilt_long", dur[3] > dur[0], 1'b1);
    check("multi_l", multi, 0);
    finish_test();
  end
endmodule
`default_nettype wire
